// File: src/stsrq_pkg.sv
// constants and carrier types of the status block
package stsrq_pkg;
	localparam int REG_W     = 8;
	localparam int IDX_W     = 4;
	localparam int CODE_W    = 14;
	localparam int ERRQ_DEPTH = 30;
	localparam int VAL_W     = 16;

	// register indices on the register port
	localparam logic [IDX_W-1:0] IDX_STD_EVENT_STATUS   = 4'h0;
	localparam logic [IDX_W-1:0] IDX_STD_EVENT_ENABLE   = 4'h1;
	localparam logic [IDX_W-1:0] IDX_STATUS_BYTE        = 4'h2;
	localparam logic [IDX_W-1:0] IDX_SERVICE_REQ_ENABLE = 4'h3;
	localparam logic [IDX_W-1:0] IDX_MOD_ERR_SUMMARY    = 4'h4;
	localparam logic [IDX_W-1:0] IDX_MOD_ERR_SUMMARY_EN = 4'h5;
	localparam logic [IDX_W-1:0] IDX_MOD_ERR_CONDITION  = 4'h6;
	localparam logic [IDX_W-1:0] IDX_MOD_ERR_EVENT      = 4'h7;
	localparam logic [IDX_W-1:0] IDX_MOD_ERR_EVENT_EN   = 4'h8;
	localparam logic [IDX_W-1:0] IDX_BLOCK_FUNC_COND    = 4'h9;
	localparam logic [IDX_W-1:0] IDX_BLOCK_FUNC_EVENT   = 4'hA;
	localparam logic [IDX_W-1:0] IDX_BLOCK_FUNC_ENABLE  = 4'hB;

	// reset values
	localparam logic [REG_W-1:0] RST_STD_EVENT = 8'h80;
	localparam logic [REG_W-1:0] RST_ZERO      = 8'h00;

	// standard event bit positions
	localparam int SE_OP_COMPLETE = 0;
	localparam int SE_REQ_CONTROL = 1;
	localparam int SE_QUERY_ERR   = 2;
	localparam int SE_DEVICE_ERR  = 3;
	localparam int SE_EXEC_ERR    = 4;
	localparam int SE_CMD_ERR     = 5;
	localparam int SE_USER_REQ    = 6;
	localparam int SE_POWER_ON    = 7;

	// status byte bit positions
	localparam int SB_FINISHED  = 0;
	localparam int SB_BLOCK_SUM = 1;
	localparam int SB_ERR_AVAIL = 2;
	localparam int SB_MOD_ERR   = 3;
	localparam int SB_MSG_AVAIL = 4;
	localparam int SB_STD_EVENT = 5;
	localparam int SB_REQ_SERV  = 6;
	localparam int SB_RESERVED  = 7;

	// block function condition bit positions
	localparam int BF_ACTIVE     = 0;
	localparam int BF_MACRO_DONE = 1;

	// error codes and group bounds
	localparam logic [CODE_W-1:0] ERR_NONE          = 14'h0000;
	localparam logic [CODE_W-1:0] ERR_OUT_OF_RANGE  = 14'h00C8; // 200
	localparam logic [CODE_W-1:0] ERR_SET_INCOMPL   = 14'h0136; // 310
	localparam logic [CODE_W-1:0] ERR_READ_INCOMPL  = 14'h0137; // 311
	localparam logic [CODE_W-1:0] ERR_TOO_MANY      = 14'h0190; // 400
	localparam logic [CODE_W-1:0] ERR_QUERY_INTR    = 14'h019A; // 410
	localparam logic [CODE_W-1:0] ERR_QUERY_UNTERM  = 14'h01A4; // 420
	localparam logic [CODE_W-1:0] GRP_CMD_LO        = 14'h0064; // 100
	localparam logic [CODE_W-1:0] GRP_EXEC_LO       = 14'h00C8; // 200
	localparam logic [CODE_W-1:0] GRP_SYS_LO        = 14'h012C; // 300
	localparam logic [CODE_W-1:0] GRP_QUERY_LO      = 14'h0190; // 400
	localparam logic [CODE_W-1:0] GRP_QUERY_HI      = 14'h01F3; // 499
	localparam logic [CODE_W-1:0] GRP_MODULE_LO     = 14'h03E8; // 1000

	typedef struct packed {
		logic             rd;
		logic             wr;
		logic [IDX_W-1:0] idx;
		logic [REG_W-1:0] wdata;
	} stsrq_reg_req_s;

	typedef struct packed {
		logic              push;
		logic [CODE_W-1:0] code;
	} stsrq_err_s;
endpackage

// File: src/stsrq_status_srq.sv
// status registers, service request and error queue
`timescale 1ns/100ps

// Functional notes
// RL1 - std event register read only, clears on read
// RL2 - power-on event bit set after power-up; bits active high
// RL3 - enabled std events ORed into status bit 5
// RL4 - status byte read only, active high
// RL5 - enabled status bits 0-5,7 drive bit 6 and SRQ
// RL6 - message-available high while response waits, else low
// RL7 - error-available high while error queue not empty
// RL8 - finished rises after command done and status update
// RL9 - summary bits flag slots that reported errors
// RL10 - only enabled slots set module-error status bit
// RL11 - module error conditions latch into clear-on-read event register
// RL12 - enabled module error events ORed into status bit 3
// RL13 - block condition: bit 0 mode active, bit 1 macro done
// RL14 - block conditions latch into clear-on-read event register
// RL15 - only enabled block events set block summary bit
// RL16 - code 400 logged once over thirty errors would be held
// RL17 - second query before read logs 410, read without query 420
// RL18 - macro start without set parameters logs 310
// RL19 - macro start without read-back parameters logs 311
// RL20 - out-of-range value logs 200, not applied
// RL21 - controller serial-polls requester when SRQ is high
// RL22 - controller ignoring SRQ reads status byte, tests bit 6
// RL23 - message-available at bit 4, cleared on output flush
// RL24 - error-available at bit 2, cleared when queue empties
// RL25 - finished at status bit 0
// RL26 - each error query returns oldest error, else code 0
// RL27 - std event bits in customary order
// RL28 - block summary at bit 1, bit 7 reads zero
// RL29 - pushed error sets its group's std event bit
module stsrq_status_srq
	import stsrq_pkg::*;
#(
	parameter int                      DEPTH   = stsrq_pkg::ERRQ_DEPTH,
	parameter logic [VAL_W-1:0]        VAL_MIN = 16'h0000,
	parameter logic [VAL_W-1:0]        VAL_MAX = 16'hFFFE
) (
	// clock and reset
	input  wire logic                      clock_in,
	input  wire logic                      rst_in,
	input  wire logic                      clk_en_in,
	// register port
	input  wire stsrq_pkg::stsrq_reg_req_s reg_req_in,
	output logic [stsrq_pkg::REG_W-1:0]    reg_rdata_out,
	output logic                           reg_rvalid_out,
	// plug-in module error lines, asynchronous
	input  wire logic [7:0]                mod_err_cond_in,
	input  wire logic [7:0]                slot_err_in,
	// block function state
	input  wire logic                      block_active_in,
	input  wire logic                      macro_done_in,
	// command execution
	input  wire logic                      cmd_start_in,
	input  wire logic                      cmd_done_in,
	input  wire logic                      clear_status_in,
	// output queue and queries
	input  wire logic                      query_in,
	input  wire logic                      host_read_in,
	input  wire logic                      out_flush_in,
	// externally detected errors
	input  wire stsrq_pkg::stsrq_err_s     err_in,
	input  wire logic                      err_query_in,
	output logic [stsrq_pkg::CODE_W-1:0]   err_code_out,
	output logic                           err_valid_out,
	// macro measurement start
	input  wire logic                      macro_start_in,
	input  wire logic                      set_params_ok_in,
	input  wire logic                      read_params_ok_in,
	output logic                           macro_go_out,
	// numeric set value
	input  wire logic                      value_wr_in,
	input  wire logic [stsrq_pkg::VAL_W-1:0] value_in,
	output logic [stsrq_pkg::VAL_W-1:0]    value_out,
	// service request
	output logic [stsrq_pkg::REG_W-1:0]    status_byte_out,
	output logic                           srq_out
);
	localparam int PTR_W = $clog2(DEPTH + 1);
	localparam int CNT_W = $clog2(DEPTH + 2);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_LIM  = CNT_W'(DEPTH);

	// two-stage synchronisers for module lines
	logic [7:0] cond_meta_ff;
	logic [7:0] cond_sync_ff;
	logic [7:0] slot_meta_ff;
	logic [7:0] slot_sync_ff;

	logic [REG_W-1:0] std_event_ff;
	logic [REG_W-1:0] std_enable_ff;
	logic [REG_W-1:0] srq_enable_ff;
	logic [REG_W-1:0] mod_sum_ff;
	logic [REG_W-1:0] mod_sum_en_ff;
	logic [REG_W-1:0] mod_event_ff;
	logic [REG_W-1:0] mod_event_en_ff;
	logic [REG_W-1:0] blk_event_ff;
	logic [REG_W-1:0] blk_enable_ff;
	logic             finished_ff;
	logic             done_seen_ff;
	logic             resp_pending_ff;
	logic [REG_W-1:0] rdata_ff;
	logic             rvalid_ff;
	logic [CODE_W-1:0] err_code_ff;
	logic             err_valid_ff;
	logic             macro_go_ff;
	logic [VAL_W-1:0] value_ff;

	// error queue storage
	logic [CODE_W-1:0] errq_mem_ff [0:DEPTH];
	logic [PTR_W-1:0]  wr_ptr_ff;
	logic [PTR_W-1:0]  rd_ptr_ff;
	logic [CNT_W-1:0]  cnt_ff;

	// register access decode
	wire rd_std_ev  = reg_req_in.rd && (reg_req_in.idx == IDX_STD_EVENT_STATUS);
	wire rd_mod_ev  = reg_req_in.rd && (reg_req_in.idx == IDX_MOD_ERR_EVENT);
	wire rd_blk_ev  = reg_req_in.rd && (reg_req_in.idx == IDX_BLOCK_FUNC_EVENT);
	wire wr_std_en  = reg_req_in.wr && (reg_req_in.idx == IDX_STD_EVENT_ENABLE);
	wire wr_srq_en  = reg_req_in.wr && (reg_req_in.idx == IDX_SERVICE_REQ_ENABLE);
	wire wr_sum_en  = reg_req_in.wr && (reg_req_in.idx == IDX_MOD_ERR_SUMMARY_EN);
	wire wr_mev_en  = reg_req_in.wr && (reg_req_in.idx == IDX_MOD_ERR_EVENT_EN);
	wire wr_blk_en  = reg_req_in.wr && (reg_req_in.idx == IDX_BLOCK_FUNC_ENABLE);

	// block function condition, only two bits live
	wire [REG_W-1:0] blk_cond = {6'h00, macro_done_in, block_active_in}; // see RL13

	// query tracking and error sources
	wire q_interrupted = query_in && resp_pending_ff; // see RL17
	wire q_unterm      = host_read_in && !resp_pending_ff && !query_in; // see RL17
	wire m_set_bad     = macro_start_in && !set_params_ok_in; // see RL18
	wire m_read_bad    = macro_start_in && set_params_ok_in && !read_params_ok_in; // see RL19
	wire v_bad         = value_wr_in && ((value_in < VAL_MIN) || (value_in > VAL_MAX)); // see RL20

	// one error per cycle; simultaneous lower-priority errors are lost
	wire               src_push = q_interrupted | q_unterm | m_set_bad | m_read_bad |
	                              v_bad | err_in.push;
	wire [CODE_W-1:0]  src_code = q_interrupted ? ERR_QUERY_INTR :
	                              q_unterm      ? ERR_QUERY_UNTERM :
	                              m_set_bad     ? ERR_SET_INCOMPL :
	                              m_read_bad    ? ERR_READ_INCOMPL :
	                              v_bad         ? ERR_OUT_OF_RANGE : err_in.code;

	// queue occupancy after a same-cycle pop
	wire               pop      = err_query_in && (cnt_ff != '0) && !clear_status_in;
	wire [CNT_W-1:0]   cnt_left = pop ? CNT_W'(cnt_ff - 1'b1) : cnt_ff;
	wire               push     = src_push && (cnt_left != CNT_FULL) && !clear_status_in;
	// last slot is kept for the overflow marker
	wire [CODE_W-1:0]  push_code = (cnt_left == CNT_LIM) ? ERR_TOO_MANY : src_code; // see RL16

	// error group of what enters the queue
	wire grp_cmd   = push && (push_code >= GRP_CMD_LO) && (push_code < GRP_EXEC_LO);
	wire grp_exec  = push && (push_code >= GRP_EXEC_LO) && (push_code < GRP_SYS_LO);
	wire grp_query = push && (push_code >= GRP_QUERY_LO) && (push_code <= GRP_QUERY_HI);
	wire grp_dev   = push && (((push_code >= GRP_SYS_LO) && (push_code < GRP_QUERY_LO)) ||
	                          (push_code >= GRP_MODULE_LO));

	wire [REG_W-1:0] std_set;
	assign std_set[SE_OP_COMPLETE] = cmd_done_in; // see RL27
	assign std_set[SE_REQ_CONTROL] = 1'b0;
	assign std_set[SE_QUERY_ERR]   = grp_query; // see RL29
	assign std_set[SE_DEVICE_ERR]  = grp_dev; // see RL29
	assign std_set[SE_EXEC_ERR]    = grp_exec; // see RL29
	assign std_set[SE_CMD_ERR]     = grp_cmd; // see RL29
	assign std_set[SE_USER_REQ]    = 1'b0;
	assign std_set[SE_POWER_ON]    = 1'b0;

	// event registers: a set in the clearing cycle survives
	wire [REG_W-1:0] nxt_std_event = ((rd_std_ev || clear_status_in) ? RST_ZERO : std_event_ff)
	                                 | std_set; // see RL1
	wire [REG_W-1:0] nxt_mod_event = ((rd_mod_ev || clear_status_in) ? RST_ZERO : mod_event_ff)
	                                 | cond_sync_ff; // see RL11
	wire [REG_W-1:0] nxt_blk_event = ((rd_blk_ev || clear_status_in) ? RST_ZERO : blk_event_ff)
	                                 | blk_cond; // see RL14
	wire [REG_W-1:0] nxt_mod_sum   = (clear_status_in ? RST_ZERO : mod_sum_ff)
	                                 | slot_sync_ff; // see RL9

	// status byte assembly
	wire std_summary = |(std_event_ff & std_enable_ff); // see RL3
	wire mod_summary = |(mod_sum_ff & mod_sum_en_ff) | |(mod_event_ff & mod_event_en_ff); // see RL10 RL12
	wire blk_summary = |(blk_event_ff & blk_enable_ff); // see RL15
	wire err_avail   = (cnt_ff != '0); // see RL7 RL24

	wire [REG_W-1:0] stb_base;
	assign stb_base[SB_FINISHED]  = finished_ff; // see RL25
	assign stb_base[SB_BLOCK_SUM] = blk_summary; // see RL28
	assign stb_base[SB_ERR_AVAIL] = err_avail; // see RL24
	assign stb_base[SB_MOD_ERR]   = mod_summary; // see RL12
	assign stb_base[SB_MSG_AVAIL] = resp_pending_ff; // see RL6 RL23
	assign stb_base[SB_STD_EVENT] = std_summary; // see RL3
	assign stb_base[SB_REQ_SERV]  = 1'b0;
	assign stb_base[SB_RESERVED]  = 1'b0; // see RL28

	// bit 6 is excluded from its own request term
	wire req_service = |(stb_base & srq_enable_ff & ~(8'h01 << SB_REQ_SERV)); // see RL5
	wire [REG_W-1:0] status_byte = stb_base | (REG_W'(req_service) << SB_REQ_SERV); // see RL4

	// read mux; unmapped indices read zero
	logic [REG_W-1:0] rd_mux;
	always_comb begin
		case (reg_req_in.idx)
			IDX_STD_EVENT_STATUS:   rd_mux = std_event_ff;
			IDX_STD_EVENT_ENABLE:   rd_mux = std_enable_ff;
			IDX_STATUS_BYTE:        rd_mux = status_byte;
			IDX_SERVICE_REQ_ENABLE: rd_mux = srq_enable_ff;
			IDX_MOD_ERR_SUMMARY:    rd_mux = mod_sum_ff;
			IDX_MOD_ERR_SUMMARY_EN: rd_mux = mod_sum_en_ff;
			IDX_MOD_ERR_CONDITION:  rd_mux = cond_sync_ff;
			IDX_MOD_ERR_EVENT:      rd_mux = mod_event_ff;
			IDX_MOD_ERR_EVENT_EN:   rd_mux = mod_event_en_ff;
			IDX_BLOCK_FUNC_COND:    rd_mux = blk_cond;
			IDX_BLOCK_FUNC_EVENT:   rd_mux = blk_event_ff;
			IDX_BLOCK_FUNC_ENABLE:  rd_mux = blk_enable_ff;
			default:                rd_mux = RST_ZERO;
		endcase
	end

	wire [PTR_W-1:0] nxt_wr_ptr = (wr_ptr_ff == PTR_LAST) ? '0 : PTR_W'(wr_ptr_ff + 1'b1);
	wire [PTR_W-1:0] nxt_rd_ptr = (rd_ptr_ff == PTR_LAST) ? '0 : PTR_W'(rd_ptr_ff + 1'b1);
	wire [CNT_W-1:0] nxt_cnt    = clear_status_in ? '0 : CNT_W'(cnt_left + CNT_W'(push));

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			cond_meta_ff <= RST_ZERO;
			cond_sync_ff <= RST_ZERO;
			slot_meta_ff <= RST_ZERO;
			slot_sync_ff <= RST_ZERO;
		end else if (clk_en_in) begin
			cond_meta_ff <= mod_err_cond_in;
			cond_sync_ff <= cond_meta_ff;
			slot_meta_ff <= slot_err_in;
			slot_sync_ff <= slot_meta_ff;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			std_event_ff <= RST_STD_EVENT; // see RL2
			mod_event_ff <= RST_ZERO;
			blk_event_ff <= RST_ZERO;
			mod_sum_ff   <= RST_ZERO;
		end else if (clk_en_in) begin
			std_event_ff <= nxt_std_event;
			mod_event_ff <= nxt_mod_event;
			blk_event_ff <= nxt_blk_event;
			mod_sum_ff   <= nxt_mod_sum;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			std_enable_ff   <= RST_ZERO;
			srq_enable_ff   <= RST_ZERO;
			mod_sum_en_ff   <= RST_ZERO;
			mod_event_en_ff <= RST_ZERO;
			blk_enable_ff   <= RST_ZERO;
		end else if (clk_en_in) begin
			if (wr_std_en)
				std_enable_ff <= reg_req_in.wdata;
			if (wr_srq_en)
				srq_enable_ff <= reg_req_in.wdata;
			if (wr_sum_en)
				mod_sum_en_ff <= reg_req_in.wdata;
			if (wr_mev_en)
				mod_event_en_ff <= reg_req_in.wdata;
			if (wr_blk_en)
				blk_enable_ff <= reg_req_in.wdata;
		end
	end

	// finished waits a cycle so other status bits settle first
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			finished_ff  <= 1'b1;
			done_seen_ff <= 1'b0;
		end else if (clk_en_in) begin
			done_seen_ff <= cmd_done_in;
			if (done_seen_ff || clear_status_in)
				finished_ff <= 1'b1; // see RL8
			else if (cmd_start_in)
				finished_ff <= 1'b0;
		end
	end

	// a new query keeps a response waiting
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in)
			resp_pending_ff <= 1'b0;
		else if (clk_en_in) begin
			if (query_in)
				resp_pending_ff <= 1'b1; // see RL6
			else if (host_read_in || out_flush_in)
				resp_pending_ff <= 1'b0; // see RL23
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_ff  <= RST_ZERO;
			rvalid_ff <= 1'b0;
		end else if (clk_en_in) begin
			rvalid_ff <= reg_req_in.rd;
			if (reg_req_in.rd)
				rdata_ff <= rd_mux;
		end
	end

	// error queue entries
	genvar gi;
	generate
		for (gi = 0; gi <= DEPTH; gi++) begin : g_errq
			always_ff @(posedge clock_in or posedge rst_in) begin
				if (rst_in)
					errq_mem_ff[gi] <= ERR_NONE;
				else if (clk_en_in && push && (wr_ptr_ff == PTR_W'(gi)))
					errq_mem_ff[gi] <= push_code;
			end
		end
	endgenerate

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end else if (clk_en_in) begin
			cnt_ff <= nxt_cnt;
			if (clear_status_in) begin
				wr_ptr_ff <= '0;
				rd_ptr_ff <= '0;
			end else begin
				if (push)
					wr_ptr_ff <= nxt_wr_ptr;
				if (pop)
					rd_ptr_ff <= nxt_rd_ptr;
			end
		end
	end

	// one answer per query, oldest first, code 0 when empty
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			err_code_ff  <= ERR_NONE;
			err_valid_ff <= 1'b0;
		end else if (clk_en_in) begin
			err_valid_ff <= err_query_in;
			if (err_query_in)
				err_code_ff <= pop ? errq_mem_ff[rd_ptr_ff] : ERR_NONE; // see RL26
		end
	end

	// rejected set values are not applied
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			value_ff    <= VAL_MIN;
			macro_go_ff <= 1'b0;
		end else if (clk_en_in) begin
			macro_go_ff <= macro_start_in && set_params_ok_in && read_params_ok_in;
			if (value_wr_in && !v_bad)
				value_ff <= value_in; // see RL20
		end
	end

	assign reg_rdata_out   = rdata_ff;
	assign reg_rvalid_out  = rvalid_ff;
	assign err_code_out    = err_code_ff;
	assign err_valid_out   = err_valid_ff;
	assign macro_go_out    = macro_go_ff;
	assign value_out       = value_ff;
	assign status_byte_out = status_byte;
	// serial poll and status query both see this as bit 6
	assign srq_out         = req_service; // see RL5 RL21 RL22
endmodule // stsrq_status_srq

// File: test/stsrq_host.sv
// host controller model on the register port
`timescale 1ns/100ps
module stsrq_host
	import stsrq_pkg::*;
(
	// clock
	input  wire logic                        clock_in,
	// register port toward the device
	output stsrq_pkg::stsrq_reg_req_s        reg_req_out,
	input  wire logic [stsrq_pkg::REG_W-1:0] reg_rdata_in,
	input  wire logic                        reg_rvalid_in
);
	initial reg_req_out = '0;
	// released idx and wdata fields show inverted values, rd and wr drop to 0
	task automatic access(input logic rd, input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] wd,
		output logic [REG_W-1:0] rdata);
		@(negedge clock_in);
		reg_req_out = '{rd: rd, wr: !rd, idx: idx, wdata: wd};
		@(negedge clock_in);
		reg_req_out = '{rd: 1'b0, wr: 1'b0, idx: ~idx, wdata: ~wd};
		rdata = (rd && reg_rvalid_in) ? reg_rdata_in : 8'hXX;
	endtask
	// status query for a controller ignoring SRQ
	task automatic poll(output logic [REG_W-1:0] sb);
		access(1'b1, IDX_STATUS_BYTE, 8'h00, sb);
	endtask
endmodule // stsrq_host

// File: test/stsrq_sva.sv
// port checks of the status block
`timescale 1ns/100ps
module stsrq_sva
	import stsrq_pkg::*;
#(
	parameter logic [VAL_W-1:0] VAL_MIN = 16'h0000,
	parameter logic [VAL_W-1:0] VAL_MAX = 16'hFFFE
) (
	// clock and reset
	input wire logic                         clock_in,
	input wire logic                         rst_in,
	// requests
	input wire stsrq_pkg::stsrq_reg_req_s    reg_req_in,
	input wire stsrq_pkg::stsrq_err_s        err_in,
	input wire logic                         err_query_in,
	input wire logic                         query_in,
	input wire logic                         host_read_in,
	input wire logic                         out_flush_in,
	input wire logic                         cmd_start_in,
	input wire logic                         cmd_done_in,
	input wire logic                         clear_status_in,
	input wire logic                         macro_start_in,
	input wire logic                         set_params_ok_in,
	input wire logic                         read_params_ok_in,
	input wire logic                         value_wr_in,
	input wire logic [stsrq_pkg::VAL_W-1:0]  value_in,
	// answers
	input wire logic                         reg_rvalid_out,
	input wire logic                         err_valid_out,
	input wire logic                         macro_go_out,
	input wire logic [stsrq_pkg::VAL_W-1:0]  value_out,
	input wire logic [stsrq_pkg::REG_W-1:0]  status_byte_out,
	input wire logic                         srq_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);
	wire range_bad = (value_in > VAL_MAX) || (value_in < VAL_MIN);
	// finished rises after the events land
	sequence s_cmd_done;
		cmd_done_in && !cmd_start_in && !clear_status_in ##1 !cmd_start_in;
	endsequence
	AST_READ_ANSWER: assert property (reg_req_in.rd |=> reg_rvalid_out)
		else $error("register read got no answer");
	AST_SRQ_BIT6: assert property (srq_out == status_byte_out[SB_REQ_SERV])
		else $error("service request differs from status bit 6");
	AST_BIT7_ZERO: assert property (status_byte_out[SB_RESERVED] == 1'b0)
		else $error("reserved status bit set");
	AST_MAV_SET: assert property (query_in && !host_read_in && !out_flush_in
		|=> status_byte_out[SB_MSG_AVAIL]) else $error("message available not set");
	AST_EAV_PUSH: assert property (err_in.push && !clear_status_in && !err_query_in
		|=> status_byte_out[SB_ERR_AVAIL]) else $error("error available not set");
	AST_ERR_ANSWER: assert property (err_query_in |=> err_valid_out)
		else $error("error query got no answer");
	AST_FIN_WAIT: assert property (cmd_done_in && !clear_status_in && !$past(cmd_done_in)
		&& !status_byte_out[SB_FINISHED] |=> !status_byte_out[SB_FINISHED])
		else $error("finished rose too early");
	AST_FIN_SET: assert property (s_cmd_done |=> status_byte_out[SB_FINISHED])
		else $error("finished not set after command");
	AST_MACRO_GO: assert property (macro_start_in && set_params_ok_in
		&& read_params_ok_in |=> macro_go_out) else $error("macro start not passed on");
	AST_VALUE_REJECT: assert property (value_wr_in && range_bad |=> $stable(value_out))
		else $error("out of range value applied");
endmodule // stsrq_sva

bind stsrq_status_srq stsrq_sva #(.VAL_MIN(VAL_MIN), .VAL_MAX(VAL_MAX)) u_stsrq_sva (.*);

// File: test/tb_top.sv
// self-checking bench of the status block
`timescale 1ns/100ps
module tb_top;
	import stsrq_pkg::*;
	localparam logic [15:0] VMAX = 16'hFFF0;
	logic              clock_in = 1'b0;
	logic              rst_in = 1'b1;
	logic              clk_en_in = 1'b1;
	logic              cmd_start_in, cmd_done_in, clear_status_in, query_in, host_read_in;
	logic              out_flush_in, err_query_in, macro_start_in, set_params_ok_in;
	logic              read_params_ok_in, value_wr_in, block_active_in, macro_done_in;
	logic              reg_rvalid_out, err_valid_out, macro_go_out, srq_out;
	logic [7:0]        mod_err_cond_in, slot_err_in, reg_rdata_out, status_byte_out, rd_val;
	logic [VAL_W-1:0]  value_in, value_out, r;
	logic [CODE_W-1:0] err_code_out, c;
	stsrq_err_s        err_in;
	stsrq_reg_req_s    reg_req_in;
	logic [IDX_W-1:0]  en_idx [5] = '{IDX_STD_EVENT_ENABLE, IDX_SERVICE_REQ_ENABLE,
		IDX_MOD_ERR_SUMMARY_EN, IDX_MOD_ERR_EVENT_EN, IDX_BLOCK_FUNC_ENABLE};
	logic [CODE_W-1:0] grp_lo [5] = '{GRP_CMD_LO, GRP_EXEC_LO, GRP_SYS_LO, GRP_QUERY_LO,
		GRP_MODULE_LO};
	int                grp_bit [5] = '{SE_CMD_ERR, SE_EXEC_ERR, SE_DEVICE_ERR, SE_QUERY_ERR,
		SE_DEVICE_ERR};
	int                err_count, comparisons, i;

	always #5 clock_in = ~clock_in;
	stsrq_status_srq #(.VAL_MAX(VMAX)) u_stsrq_status_srq (.*);
	stsrq_host u_stsrq_host (.clock_in(clock_in), .reg_req_out(reg_req_in),
		.reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge clock_in);
		s = 1'b1;
		@(negedge clock_in);
		s = 1'b0;
	endtask
	task automatic acc(input logic rd, input logic [IDX_W-1:0] idx, input logic [7:0] d);
		u_stsrq_host.access(rd, idx, d, rd_val);
	endtask
	task automatic rchk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
		acc(1'b1, idx, 8'h00);
		chk("register", 16'(exp), 16'(rd_val));
	endtask
	task automatic push(input logic [CODE_W-1:0] code);
		@(negedge clock_in);
		err_in = '{push: 1'b1, code: code};
		@(negedge clock_in);
		err_in = '{push: 1'b0, code: ~code};
	endtask
	task automatic errq(input logic [CODE_W-1:0] exp);
		pulse(err_query_in);
		chk("error answer", {2'b01, exp}, {1'b0, err_valid_out, err_code_out});
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		{cmd_start_in, cmd_done_in, clear_status_in, query_in, host_read_in, out_flush_in} = '0;
		{err_query_in, macro_start_in, set_params_ok_in, read_params_ok_in, value_wr_in} = '0;
		{block_active_in, macro_done_in, mod_err_cond_in, slot_err_in, value_in, err_in} = '0;
		void'($urandom(32'hB1CA));
		repeat (20) @(negedge clock_in);
		rst_in = 1'b0;
		chk("status byte", 16'h0001, 16'(status_byte_out));
		rchk(IDX_STD_EVENT_STATUS, RST_STD_EVENT);
		rchk(IDX_STD_EVENT_STATUS, 8'h00);
		foreach (en_idx[k]) begin
			r = 16'($urandom);
			acc(1'b0, en_idx[k], r[7:0]);
			rchk(en_idx[k], r[7:0]);
			acc(1'b0, en_idx[k], 8'h00);
		end
		acc(1'b0, IDX_STATUS_BYTE, 8'hFF);
		rchk(IDX_STATUS_BYTE, 8'h01);
		rchk(4'hF, 8'h00);
		acc(1'b0, IDX_STD_EVENT_ENABLE, 8'hFF);
		acc(1'b0, IDX_SERVICE_REQ_ENABLE, 8'h20);
		// one random code per error group
		for (i = 0; i < 5; i++) begin
			c = grp_lo[i] + CODE_W'($urandom_range(0, 99));
			push(c);
			chk("summary", 16'h0060, 16'(status_byte_out & 8'h60));
			u_stsrq_host.poll(rd_val);
			chk("poll", 16'h0001, 16'(rd_val[SB_REQ_SERV]));
			rchk(IDX_STD_EVENT_STATUS, 8'h01 << grp_bit[i]);
			errq(c);
			chk("err avail", 16'h0000, 16'(status_byte_out[SB_ERR_AVAIL]));
		end
		for (i = 0; i < 32; i++) push(CODE_W'(100 + i));
		for (i = 0; i < 30; i++) errq(CODE_W'(100 + i));
		errq(ERR_TOO_MANY);
		errq(ERR_NONE);
		pulse(query_in);
		chk("msg avail", 16'h0001, 16'(status_byte_out[SB_MSG_AVAIL]));
		pulse(query_in);
		pulse(host_read_in);
		chk("msg avail", 16'h0000, 16'(status_byte_out[SB_MSG_AVAIL]));
		pulse(host_read_in);
		errq(ERR_QUERY_INTR);
		errq(ERR_QUERY_UNTERM);
		pulse(query_in);
		pulse(out_flush_in);
		chk("msg avail", 16'h0000, 16'(status_byte_out[SB_MSG_AVAIL]));
		pulse(macro_start_in);
		set_params_ok_in = 1'b1;
		pulse(macro_start_in);
		read_params_ok_in = 1'b1;
		pulse(macro_start_in);
		chk("macro go", 16'h0001, 16'(macro_go_out));
		errq(ERR_SET_INCOMPL);
		errq(ERR_READ_INCOMPL);
		r = 16'($urandom_range(0, VMAX));
		value_in = r;
		pulse(value_wr_in);
		value_in = 16'hFFFF;
		pulse(value_wr_in);
		chk("value", r, value_out);
		errq(ERR_OUT_OF_RANGE);
		// only macro-done enabled toward summary
		acc(1'b0, IDX_BLOCK_FUNC_ENABLE, 8'h02);
		block_active_in = 1'b1;
		repeat (2) @(negedge clock_in);
		chk("block sum", 16'h0000, 16'(status_byte_out[SB_BLOCK_SUM]));
		macro_done_in = 1'b1;
		rchk(IDX_BLOCK_FUNC_COND, 8'h03);
		chk("block sum", 16'h0001, 16'(status_byte_out[SB_BLOCK_SUM]));
		{block_active_in, macro_done_in} = 2'b00;
		repeat (2) @(negedge clock_in);
		rchk(IDX_BLOCK_FUNC_EVENT, 8'h03);
		rchk(IDX_BLOCK_FUNC_EVENT, 8'h00);
		// module lines pass a two-stage synchroniser
		r = 16'(1 << $urandom_range(0, 7));
		acc(1'b0, IDX_MOD_ERR_EVENT_EN, r[7:0]);
		mod_err_cond_in = r[7:0];
		repeat (4) @(negedge clock_in);
		chk("module err", 16'h0001, 16'(status_byte_out[SB_MOD_ERR]));
		mod_err_cond_in = 8'h00;
		slot_err_in = ~r[7:0];
		repeat (4) @(negedge clock_in);
		slot_err_in = 8'h00;
		rchk(IDX_MOD_ERR_EVENT, r[7:0]);
		rchk(IDX_MOD_ERR_SUMMARY, ~r[7:0]);
		chk("module err", 16'h0000, 16'(status_byte_out[SB_MOD_ERR]));
		acc(1'b0, IDX_MOD_ERR_SUMMARY_EN, ~r[7:0]);
		chk("module err", 16'h0001, 16'(status_byte_out[SB_MOD_ERR]));
		pulse(clear_status_in);
		pulse(cmd_start_in);
		chk("finished", 16'h0000, 16'(status_byte_out[SB_FINISHED]));
		pulse(cmd_done_in);
		chk("finished", 16'h0000, 16'(status_byte_out[SB_FINISHED]));
		@(negedge clock_in);
		chk("finished", 16'h0001, 16'(status_byte_out[SB_FINISHED]));
		rchk(IDX_STD_EVENT_STATUS, 8'h01);
		results();
	end

	initial begin
		repeat (4000) @(posedge clock_in);
		err_count++;
		results();
	end
endmodule // tb_top
